// file: inc/usr_pkg.sv
`default_nettype none
package usr_pkg;
   // register offsets, low three address bits
   localparam logic [2:0] OFS_TX_HOLD = 3'h0;
   localparam logic [2:0] OFS_IER = 3'h1;
   localparam logic [2:0] OFS_BANK2 = 3'h2;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [2:0] OFS_BANK4 = 3'h4;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_STATUS = 3'h5;
   localparam logic [2:0] OFS_BANK5 = 3'h5;
   localparam logic [2:0] OFS_BANK6 = 3'h6;
   localparam logic [2:0] OFS_BANK7 = 3'h7;
   localparam logic [2:0] OFS_EXT_BANK = 3'h7;
   // bank select codes and the enhanced-bank key
   localparam logic [1:0] BANK_NORMAL = 2'h0;
   localparam logic [1:0] BANK_FIRST = 2'h1;
   localparam logic [1:0] BANK_SECOND = 2'h2;
   localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
   localparam logic [7:0] REG_RESET = 8'h00;
   // field positions, prescaler fraction width and default idle count
   localparam int IER_SLEEP = 4;
   localparam int IER_LSI = 2;
   localparam int EFR_ENH = 4;
   localparam int EFR_SPECIAL = 5;
   localparam int EFR_AUTO_RTS = 6;
   localparam int MCR_RTS = 1;
   localparam int AMC_SLEEP_RX = 4;
   localparam int ARC_NINE_BIT = 0;
   localparam int ARC_RX_DIS = 1;
   localparam int ARC_AUTO_RTS = 4;
   localparam int ARC_RTS_INV = 5;
   localparam int EXB_SEL_LO = 1;
   localparam int EXB_SEL_HI = 2;
   localparam int CLOCK_PRESCALER_FRACTION_W = 4;
   localparam int IDLE_CHARS_DEF = 4;

   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_ASLEEP = 2'b01,
      ST_LOW_POWER_PIN = 2'b10
   } usr_pwr_state_t;

   // host register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } usr_bus_req_t;

   // received character from the receive shifter
   typedef struct packed {
      logic valid;
      logic ninth;
      logic perr;
      logic [7:0] data;
   } usr_rx_char_t;

   // character pushed into the receive fifo
   typedef struct packed {
      logic push;
      logic perr;
      logic [7:0] data;
   } usr_rx_push_t;
endpackage
`default_nettype wire

// file: core/usr_ctrl.sv
// Behaviour
// - sleep allowed only with enhanced enable and interrupt-enable sleep bit set
// - sleep needs static modem, rx idle four chars, tx empty, no irq, rx empty
// - sleep-ignores-rx bit drops the rx idle check
// - asleep stops uart core clock and baud clock
// - start bit, tx fifo write or modem change wakes the device
// - after wake, sleep re-enters when conditions hold, until sleep bit cleared
// - low power pin high stops clocks and isolates host pins on the next clock
// - rts source: auto rs485 first, then flow control, then modem-control bit
// - auto mode drives rts low on tx write, high after last bit
// - inversion bit makes rts high while pending, low when done
// - aux control bit 0 enables 9-bit mode, ninth bit 1 is address
// - manual mode drops data while disabled, stores address with parity error
// - enabled manual receiver keeps data, further address flags parity error
// - auto match discards others, self-enables on match, stores and signals
// - auto match disables on non-matching address, match stores ninth bit
// - enhanced registers reachable only with lcr 0xbf and bank bits zero
// - bank 01 maps first extra set, bank 10 maps second extra set
// - address compare uses only word-length low bits, bit 0 first
`timescale 1ns/10ps
`default_nettype none
module usr_ctrl
   import usr_pkg::*;
#(
   parameter int IDLE_CHARS = IDLE_CHARS_DEF
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // host register port
   input wire usr_bus_req_t bus_i,
   output logic [7:0] bus_rdata_o,
   // power pins and core status
   input wire logic low_power_pin_i,
   input wire logic rx_pin_i,
   input wire logic [3:0] modem_in_i,
   input wire logic char_tick_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_shift_empty_i,
   input wire logic irq_pending_i,
   input wire logic rx_fifo_empty_i,
   output logic uart_clk_en_o,
   output logic baud_clk_en_o,
   output logic host_isolate_o,
   output logic tx_fifo_write_o,
   // request-to-send
   input wire logic flow_rts_n_i,
   output logic rts_n_o,
   // receive path
   input wire usr_rx_char_t rx_char_i,
   output usr_rx_push_t rx_push_o,
   output logic line_status_irq_o
);
   // refuse idle counts that the 8-bit counter cannot hold
   if (IDLE_CHARS < 1 || IDLE_CHARS > 255) begin : g_bad_idle
      $error("IDLE_CHARS out of range");
   end

   // mask of the word length, bit 0 is the first data bit
   function automatic logic [7:0] word_mask(input logic [1:0] wl);
      word_mask = 8'hff >> (3'h3 - {1'b0, wl});
   endfunction

   logic [7:0] ier_q, lcr_q, mcr_q, exb_q, efr_q;
   logic [7:0] xon_lo_q, xon_hi_q, xoff_lo_q, xoff_adr_q;
   logic [7:0] txl_q, rxl_q, fth_q, ftl_q;
   logic [CLOCK_PRESCALER_FRACTION_W-1:0] pres_q;
   logic [7:0] dly_q, arc_q, amc_q;
   usr_pwr_state_t state_q, state_d;
   logic [3:0] modem_q;
   logic [7:0] idle_cnt_q;
   logic rx_auto_en_q;
   logic rts_n_q;
   usr_rx_push_t push_q;
   logic lsi_q;
   logic [7:0] rdata_q;

   // bank decode: extra banks take the place of the normal registers
   wire logic [1:0] bank_sel = {exb_q[EXB_SEL_HI], exb_q[EXB_SEL_LO]};
   wire logic sel_first = bank_sel == BANK_FIRST;
   wire logic sel_second = bank_sel == BANK_SECOND;
   wire logic sel_enh = (lcr_q == LCR_ENH_KEY) && (bank_sel == BANK_NORMAL);
   wire logic sel_norm = !sel_first && !sel_second && !sel_enh;
   wire logic wr = bus_i.wr;
   wire logic [2:0] a = bus_i.addr;
   wire logic [7:0] wd = bus_i.wdata;
   // lcr stays reachable in every bank; bank control is writable only in the normal bank, so extra banks are left through reset
   wire logic wr_lcr = wr && a == OFS_LCR; // word length must stay settable in every bank
   wire logic wr_exb = wr && a == OFS_EXT_BANK && (sel_norm || sel_first || sel_second)
                       && !(sel_second || sel_first) || wr && a == OFS_EXT_BANK && sel_norm;
   wire logic wr_thr = wr && sel_norm && a == OFS_TX_HOLD && !lcr_q[7];
   wire logic wr_arc = wr && sel_second && a == OFS_BANK6;

   // register writes
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ier_q <= REG_RESET;
         lcr_q <= REG_RESET;
         mcr_q <= REG_RESET;
         exb_q <= REG_RESET;
         efr_q <= REG_RESET;
         xon_lo_q <= REG_RESET;
         xon_hi_q <= REG_RESET;
         xoff_lo_q <= REG_RESET;
         xoff_adr_q <= REG_RESET;
         txl_q <= REG_RESET;
         rxl_q <= REG_RESET;
         fth_q <= REG_RESET;
         ftl_q <= REG_RESET;
         pres_q <= '0;
         dly_q <= REG_RESET;
         arc_q <= REG_RESET;
         amc_q <= REG_RESET;
      end else if (wr) begin
         if (wr_lcr) lcr_q <= wd;
         if (wr_exb) exb_q <= wd;
         if (sel_norm && a == OFS_IER) ier_q <= wd;
         if (sel_norm && a == OFS_MCR) mcr_q <= wd;
         if (sel_enh && a == OFS_BANK2) efr_q <= wd;
         if (sel_enh && a == OFS_BANK4) xon_lo_q <= wd;
         if (sel_enh && a == OFS_BANK5) xon_hi_q <= wd;
         if (sel_enh && a == OFS_BANK6) xoff_lo_q <= wd;
         if (sel_enh && a == OFS_BANK7) xoff_adr_q <= wd;
         if (sel_first && a == OFS_BANK2) txl_q <= wd;
         if (sel_first && a == OFS_BANK4) rxl_q <= wd;
         if (sel_first && a == OFS_BANK6) fth_q <= wd;
         if (sel_first && a == OFS_BANK7) ftl_q <= wd;
         if (sel_second && a == OFS_BANK2) pres_q <= wd[CLOCK_PRESCALER_FRACTION_W-1:0];
         if (sel_second && a == OFS_BANK4) dly_q <= wd;
         if (wr_arc) arc_q <= wd;
         if (sel_second && a == OFS_BANK7) amc_q <= wd;
      end
   end

   // read mux, unmapped offsets read zero
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      if (sel_first) begin
         case (a)
            OFS_BANK2: rmux = txl_q;
            OFS_BANK4: rmux = rxl_q;
            OFS_BANK6: rmux = fth_q;
            OFS_BANK7: rmux = ftl_q;
            OFS_LCR: rmux = lcr_q;
            default: rmux = 8'h00;
         endcase
      end else if (sel_second) begin
         case (a)
            OFS_BANK2: rmux = {{(8-CLOCK_PRESCALER_FRACTION_W){1'b0}}, pres_q};
            OFS_BANK4: rmux = dly_q;
            OFS_BANK6: rmux = arc_q;
            OFS_BANK7: rmux = amc_q;
            OFS_LCR: rmux = lcr_q;
            default: rmux = 8'h00;
         endcase
      end else if (sel_enh) begin
         case (a)
            OFS_BANK2: rmux = efr_q;
            OFS_LCR: rmux = lcr_q;
            OFS_BANK4: rmux = xon_lo_q;
            OFS_BANK5: rmux = xon_hi_q;
            OFS_BANK6: rmux = xoff_lo_q;
            OFS_BANK7: rmux = xoff_adr_q;
            default: rmux = 8'h00;
         endcase
      end else begin
         case (a)
            OFS_IER: rmux = ier_q;
            OFS_LCR: rmux = lcr_q;
            OFS_MCR: rmux = mcr_q;
            OFS_STATUS: rmux = {5'h00, rx_auto_en_q, rts_n_q, state_q == ST_ASLEEP};
            OFS_EXT_BANK: rmux = exb_q;
            default: rmux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) rdata_q <= 8'h00;
      else if (bus_i.rd) rdata_q <= rmux;
   end

   // sleep entry and wake, on the always-on clock so wake needs no uart clock
   wire logic sleep_en = efr_q[EFR_ENH] && ier_q[IER_SLEEP];
   wire logic modem_chg = modem_in_i != modem_q;
   wire logic rx_idle = (idle_cnt_q >= 8'(IDLE_CHARS)) || amc_q[AMC_SLEEP_RX];
   wire logic can_sleep = sleep_en && !modem_chg && rx_idle && tx_fifo_empty_i
                          && tx_shift_empty_i && !irq_pending_i && rx_fifo_empty_i;
   wire logic wake_evt = !rx_pin_i || wr_thr || modem_chg;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_AWAKE: if (can_sleep) state_d = ST_ASLEEP;
         ST_ASLEEP: if (wake_evt || !sleep_en) state_d = ST_AWAKE;
         ST_LOW_POWER_PIN: if (!low_power_pin_i) state_d = ST_AWAKE;
         default: state_d = ST_AWAKE;
      endcase
      if (low_power_pin_i) state_d = ST_LOW_POWER_PIN;
   end

   // idle count only advances on character ticks, which stop while asleep
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q <= ST_AWAKE;
         modem_q <= 4'h0;
         idle_cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         modem_q <= modem_in_i;
         if (!rx_pin_i) idle_cnt_q <= 8'h00;
         else if (char_tick_i && idle_cnt_q < 8'(IDLE_CHARS)) idle_cnt_q <= idle_cnt_q + 8'h01;
      end
   end

   // clock gates follow the state at once
   assign uart_clk_en_o = state_q == ST_AWAKE;
   assign baud_clk_en_o = state_q == ST_AWAKE;
   assign host_isolate_o = state_q == ST_LOW_POWER_PIN;
   assign tx_fifo_write_o = wr_thr;

   // rts source select; auto mode takes priority even when flow control is on
   wire logic tx_pending = wr_thr || !tx_fifo_empty_i || !tx_shift_empty_i;
   wire logic auto_lvl = arc_q[ARC_RTS_INV] ? tx_pending : !tx_pending;
   wire logic rts_d = arc_q[ARC_AUTO_RTS] ? auto_lvl
                    : efr_q[EFR_AUTO_RTS] ? flow_rts_n_i : !mcr_q[MCR_RTS];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) rts_n_q <= 1'b1;
      else rts_n_q <= rts_d;
   end
   assign rts_n_o = rts_n_q;

   // multidrop receive filter
   wire logic nine_en = arc_q[ARC_NINE_BIT];
   wire logic auto_mt = nine_en && efr_q[EFR_SPECIAL];
   wire logic is_adr = rx_char_i.valid && nine_en && rx_char_i.ninth;
   wire logic [7:0] msk = word_mask(lcr_q[1:0]);
   wire logic adr_hit = (rx_char_i.data & msk) == (xoff_adr_q & msk);
   wire logic man_en = !arc_q[ARC_RX_DIS];
   logic keep;
   logic keep_perr;
   always_comb begin
      keep = rx_char_i.valid;
      keep_perr = rx_char_i.perr;
      if (auto_mt) begin
         keep = rx_char_i.valid && (is_adr ? adr_hit : rx_auto_en_q);
         keep_perr = is_adr ? 1'b1 : rx_char_i.perr;
      end else if (nine_en) begin
         keep = rx_char_i.valid && (is_adr || man_en);
         keep_perr = is_adr ? 1'b1 : rx_char_i.perr;
      end
   end

   // match wins over a software disable arriving in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_auto_en_q <= 1'b0;
         push_q <= '0;
         lsi_q <= 1'b0;
      end else begin
         if (auto_mt && is_adr) rx_auto_en_q <= adr_hit;
         else if (wr_arc && wd[ARC_RX_DIS]) rx_auto_en_q <= 1'b0;
         push_q.push <= keep;
         push_q.perr <= keep_perr;
         push_q.data <= rx_char_i.data;
         lsi_q <= keep && is_adr && ier_q[IER_LSI];
      end
   end
   assign rx_push_o = push_q;
   assign line_status_irq_o = lsi_q;
   assign bus_rdata_o = rdata_q;

   // checks
   a_sleep_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_ASLEEP |-> sleep_en || $past(sleep_en)) else $error("asleep without enable");
   a_sleep_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_q == ST_AWAKE && !low_power_pin_i ##1 state_q == ST_ASLEEP)
      |-> $past(tx_fifo_empty_i && rx_fifo_empty_i && !irq_pending_i))
      else $error("sleep entered while busy");
   a_clock_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_ASLEEP |-> !uart_clk_en_o && !baud_clk_en_o) else $error("clock running asleep");
   a_wake_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_ASLEEP && !rx_pin_i && !low_power_pin_i |=> uart_clk_en_o)
      else $error("no wake on start bit");
   a_low_power: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      low_power_pin_i |=> host_isolate_o && !uart_clk_en_o) else $error("low power ignored");
   a_rts_auto: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      arc_q[ARC_AUTO_RTS] && !arc_q[ARC_RTS_INV] && (wr_thr || !tx_fifo_empty_i)
      |=> !rts_n_o) else $error("rts not driven low");
   a_rts_inv: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      arc_q[ARC_AUTO_RTS] && arc_q[ARC_RTS_INV] && !tx_pending ##1 arc_q[ARC_AUTO_RTS]
      && arc_q[ARC_RTS_INV] |-> !rts_n_o) else $error("inverted rts wrong");
   a_addr_store: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      is_adr && !auto_mt |=> rx_push_o.push && rx_push_o.perr) else $error("address lost");
   a_auto_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      auto_mt && is_adr && !adr_hit |=> !rx_push_o.push && !rx_auto_en_q)
      else $error("mismatch kept");
   // source priority, sleep and low power bookkeeping, bank lock
   a_rts_flow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !arc_q[ARC_AUTO_RTS] && efr_q[EFR_AUTO_RTS] |=> rts_n_o == $past(flow_rts_n_i))
      else $error("rts not from flow control");
   a_rts_mcr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !arc_q[ARC_AUTO_RTS] && !efr_q[EFR_AUTO_RTS] |=> rts_n_o == !$past(mcr_q[MCR_RTS]))
      else $error("rts not from modem control");
   a_sleep_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_q == ST_AWAKE && !low_power_pin_i ##1 state_q == ST_ASLEEP)
      |-> $past(tx_shift_empty_i && modem_in_i == modem_q
      && (amc_q[AMC_SLEEP_RX] || idle_cnt_q >= 8'(IDLE_CHARS))))
      else $error("sleep while line active");
   a_sleep_exit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_ASLEEP && !sleep_en && !low_power_pin_i |=> state_q == ST_AWAKE)
      else $error("sleep kept after disable");
   a_tx_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_ASLEEP && wr_thr && !low_power_pin_i |=> uart_clk_en_o) else $error("no tx wake");
   a_low_exit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_LOW_POWER_PIN && !low_power_pin_i |=> uart_clk_en_o && !host_isolate_o)
      else $error("low power not left");
   a_bank_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      bus_i.wr && !sel_enh |=> $stable(efr_q)) else $error("efr written outside its bank");
   // multidrop receive filter
   a_rx_pass: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      rx_char_i.valid && !nine_en |=> rx_push_o.push && rx_push_o.perr == $past(rx_char_i.perr))
      else $error("plain char not passed");
   a_rx_dropped: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      nine_en && !auto_mt && rx_char_i.valid && !is_adr && arc_q[ARC_RX_DIS]
      |=> !rx_push_o.push) else $error("data kept while disabled");
   a_auto_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      auto_mt && rx_char_i.valid && !is_adr && !rx_auto_en_q
      |=> !rx_push_o.push) else $error("data kept before match");
   a_auto_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      auto_mt && is_adr && adr_hit |=> rx_auto_en_q && rx_push_o.push && rx_push_o.perr)
      else $error("match not stored");
   a_lsi_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      line_status_irq_o |-> rx_push_o.push && rx_push_o.perr) else $error("stray line irq");
   c_sleep_wake: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_ASLEEP ##1 state_q == ST_AWAKE);
   c_low_power: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == ST_LOW_POWER_PIN);
   c_auto_match: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      auto_mt && is_adr && adr_hit);
   c_rts_auto: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      arc_q[ARC_AUTO_RTS] && !tx_fifo_empty_i ##1 !rts_n_o);
   c_addr_irq: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      line_status_irq_o);
endmodule // usr_ctrl
`default_nettype wire

// file: testbench/usr_station.sv
`timescale 1ns/10ps
`default_nettype none
module usr_station
   import usr_pkg::*;
(
   // clock
   input wire logic clk_sys_i,
   // line towards the block
   output logic rx_pin_o,
   output usr_rx_char_t rx_char_o
);
   // line idles high in mark state
   initial begin
      rx_pin_o = 1'b1;
      rx_char_o = '0;
   end
   // start bit low for two cycles, then the assembled char
   task automatic send(input logic ninth, input logic [7:0] data, input logic deliver);
      @(negedge clk_sys_i);
      rx_pin_o <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
      rx_pin_o <= 1'b1;
      rx_char_o <= {deliver, ninth, 1'b0, data}; // ninth bit flags an address
      @(negedge clk_sys_i);
      rx_char_o <= {1'b0, ~ninth, 1'b0, ~data}; // stale fields must not look valid
   endtask
endmodule // usr_station
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import usr_pkg::*;
   logic clk_sys_i, rst_n_i, low_power_pin_i, char_tick_i, tx_fifo_empty_i, tx_shift_empty_i;
   logic irq_pending_i, rx_fifo_empty_i, flow_rts_n_i, rx_pin_i, uart_clk_en_o, baud_clk_en_o;
   logic host_isolate_o, tx_fifo_write_o, rts_n_o, line_status_irq_o;
   logic [3:0] modem_in_i;
   logic [7:0] bus_rdata_o;
   logic [1:0] tick_cnt;
   logic [31:0] seed;
   usr_bus_req_t bus_i;
   usr_rx_char_t rx_char_i;
   usr_rx_push_t rx_push_o;
   logic [9:0] exp_q[$];
   int num_errors = 0;
   int n_checks = 0;

   usr_ctrl #(.IDLE_CHARS(1)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
      .bus_rdata_o(bus_rdata_o), .low_power_pin_i(low_power_pin_i), .rx_pin_i(rx_pin_i),
      .modem_in_i(modem_in_i), .char_tick_i(char_tick_i), .tx_fifo_empty_i(tx_fifo_empty_i),
      .tx_shift_empty_i(tx_shift_empty_i), .irq_pending_i(irq_pending_i),
      .rx_fifo_empty_i(rx_fifo_empty_i), .uart_clk_en_o(uart_clk_en_o),
      .baud_clk_en_o(baud_clk_en_o), .host_isolate_o(host_isolate_o),
      .tx_fifo_write_o(tx_fifo_write_o), .flow_rts_n_i(flow_rts_n_i), .rts_n_o(rts_n_o),
      .rx_char_i(rx_char_i), .rx_push_o(rx_push_o), .line_status_irq_o(line_status_irq_o));
   usr_station i_station (.clk_sys_i(clk_sys_i), .rx_pin_o(rx_pin_i), .rx_char_o(rx_char_i));

   // 25 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   // one character time every four cycles keeps idle counting short
   always @(negedge clk_sys_i) begin
      tick_cnt <= (rst_n_i === 1'b1) ? tick_cnt + 2'd1 : 2'd0;
      char_tick_i <= (tick_cnt == 2'd3);
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic fail(input string m);
      $display("[ERR] %0t %s", $time, m);
      num_errors++;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp) fail(m);
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [7:0] rnd();
      seed = xs(seed);
      return seed[7:0];
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      bus_i <= '{1'b1, 1'b0, a, d};
      @(negedge clk_sys_i);
      bus_i <= '0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(negedge clk_sys_i);
      bus_i <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_sys_i);
      bus_i <= '0;
      chk(bus_rdata_o, exp, "read data");
   endtask
   // rts is registered one cycle behind its cause
   task automatic rts_is(input logic v);
      @(negedge clk_sys_i);
      @(negedge clk_sys_i);
      chk({7'h0, rts_n_o}, {7'h0, v}, "rts level");
   endtask
   task automatic wait_en(input logic v);
      int i;
      for (i = 0; i < 64 && uart_clk_en_o !== v; i++) @(negedge clk_sys_i);
      chk({6'h0, uart_clk_en_o, baud_clk_en_o}, {6'h0, v, v}, "clock enables");
      if (i >= 64) finish_test();
   endtask
   // note the expected push, then let the station send
   task automatic rx(input logic nin, input logic [7:0] d, input logic keep, input logic pe);
      if (keep) exp_q.push_back({nin & pe, pe, d});
      i_station.send(nin, d, 1'b1);
      repeat (3) @(negedge clk_sys_i);
   endtask
   task automatic do_reset();
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_n_i <= 1'b1;
   endtask

   // every push is matched against the oldest note
   always @(negedge clk_sys_i) begin
      if (rx_push_o.push === 1'b1) begin
         n_checks++;
         if (exp_q.size() == 0) fail("unexpected push");
         else if ({line_status_irq_o, rx_push_o.perr, rx_push_o.data}
                  !== exp_q.pop_front())
            fail("push mismatch");
      end
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      fail("timeout");
      finish_test();
   end

   initial begin
      seed = 32'h0e9d;
      tick_cnt = 2'd0;
      char_tick_i = 1'b0;
      rst_n_i = 1'b0;
      bus_i = '0;
      {low_power_pin_i, irq_pending_i, modem_in_i} = '0;
      {tx_fifo_empty_i, tx_shift_empty_i, rx_fifo_empty_i, flow_rts_n_i} = 4'hf;
      do_reset();
      rd(OFS_IER, REG_RESET);
      chk({7'h0, rts_n_o}, 8'h01, "rts after reset");
      wr(OFS_MCR, 8'h02);
      rts_is(1'b0);
      wr(OFS_LCR, LCR_ENH_KEY);
      flow_rts_n_i <= 1'b0;
      wr(OFS_BANK2, 8'h50);
      rts_is(1'b0);
      flow_rts_n_i <= 1'b1;
      rts_is(1'b1);
      rd(OFS_BANK2, 8'h50);
      wr(OFS_BANK2, 8'h10);
      wr(OFS_LCR, 8'h03);
      rd(OFS_BANK2, 8'h00);
      // pending interrupt blocks sleep even when enabled
      irq_pending_i <= 1'b1;
      wr(OFS_IER, 8'h14);
      repeat (20) @(negedge clk_sys_i);
      wait_en(1'b1);
      irq_pending_i <= 1'b0;
      wait_en(1'b0);
      i_station.send(1'b0, 8'h00, 1'b0);
      wait_en(1'b1);
      wait_en(1'b0);
      modem_in_i <= 4'(rnd()) | 4'h1;
      wait_en(1'b1);
      wait_en(1'b0);
      @(negedge clk_sys_i);
      bus_i <= '{1'b1, 1'b0, OFS_TX_HOLD, rnd()};
      @(negedge clk_sys_i);
      chk({7'h0, tx_fifo_write_o}, 8'h01, "fifo write strobe");
      bus_i <= '0;
      wait_en(1'b1);
      wait_en(1'b0);
      wr(OFS_IER, 8'h04); // sleep off before the low power pin test
      wait_en(1'b1);
      low_power_pin_i <= 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk({6'h0, host_isolate_o, uart_clk_en_o}, 8'h02, "low power entry");
      low_power_pin_i <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk({6'h0, host_isolate_o, uart_clk_en_o}, 8'h01, "low power exit");
      // manual multidrop in the second extra bank, flow control off
      wr(OFS_EXT_BANK, 8'h04);
      rx(1'b1, 8'h81, 1'b1, 1'b0); // 9-bit off: ninth bit ignored
      wr(OFS_BANK6, 8'h03);
      rd(OFS_BANK6, 8'h03);
      rx(1'b0, rnd(), 1'b0, 1'b0);
      rx(1'b1, 8'h2a, 1'b1, 1'b1);
      wr(OFS_BANK6, 8'h01); // 9-bit mode on, enable receiver
      rx(1'b0, rnd(), 1'b1, 1'b0);
      rx(1'b1, 8'h3c, 1'b1, 1'b1);
      // auto direction and its inverted form, flow control off
      wr(OFS_BANK6, 8'h10);
      tx_fifo_empty_i <= 1'b0;
      rts_is(1'b0);
      tx_fifo_empty_i <= 1'b1;
      rts_is(1'b1);
      wr(OFS_BANK6, 8'h30);
      tx_shift_empty_i <= 1'b0;
      rts_is(1'b1);
      tx_shift_empty_i <= 1'b1;
      rts_is(1'b0);
      // extra banks are left through reset only
      do_reset();
      wr(OFS_LCR, LCR_ENH_KEY);
      wr(OFS_BANK2, 8'h30);
      wr(OFS_BANK7, 8'h55);
      wr(OFS_LCR, 8'h03);
      wr(OFS_IER, 8'h04);
      wr(OFS_EXT_BANK, 8'h04);
      wr(OFS_BANK6, 8'h01);
      rx(1'b0, rnd(), 1'b0, 1'b0);
      rx(1'b1, 8'h12, 1'b0, 1'b0);
      rx(1'b1, 8'h55, 1'b1, 1'b1);
      rx(1'b0, rnd(), 1'b1, 1'b0);
      rx(1'b1, 8'h12, 1'b0, 1'b0);
      rx(1'b0, rnd(), 1'b0, 1'b0);
      wr(OFS_LCR, 8'h00);
      rx(1'b1, 8'hf5, 1'b1, 1'b1);
      do_reset();
      wr(OFS_EXT_BANK, 8'h02);
      wr(OFS_BANK4, 8'h6b);
      rd(OFS_BANK4, 8'h6b);
      rd(OFS_BANK2, REG_RESET);
      repeat (5) @(negedge clk_sys_i);
      chk(8'(exp_q.size()), 8'h00, "pushes missing");
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
